// ==== rtl/cosd_pkg.sv ====
// Purpose: Constants for the CAN object status, payload and interrupt enable block
// Assumes: APB byte address equals four times the register index
// Notes:   Bit pairs hold a true bit above its complement
//
// What this block does
// - Receive store while fresh set marks the object overwritten (pair 10).
// - Host editing set blocks answering a remote frame for that object.
// - Every receive store into an object sets its fresh content pair.
// - Fifteen objects with eight payload bytes each; reset keeps their contents.
// - Payload bytes past the length may hold anything and may change.
// - Received payload bytes are written into the object's payload registers.
// - All interrupt sources share one interrupt request line.
// - Control bit 3 enables bus-off and warning interrupts.
// - Control bit 2 enables receive-ok, transmit-ok and error-kind change interrupts.
// - With status change enabled, each valid message raises a receive-ok request.
// - Control bit 1 is the global interrupt enable.
// - Interrupt only when global enable and the source enable are both set.
// - With global enable clear, pending source still updates, no interrupt.
// - Status change plus object receive enable give two requests per message.
// - Pair write 10 sets, 01 clears, 11 keeps; reads give 10 or 01.
package cosd_pkg;
    // ==========================================
    // Register indices (byte address = index * 4)
    localparam logic [13:0] IDX_CTL      = 14'h1e00;
    localparam logic [13:0] IDX_STAT     = 14'h1e01;
    localparam logic [13:0] IDX_PEND     = 14'h1e02;
    localparam logic [5:0]  IDX_PAGE     = 6'h1e;
    localparam logic [3:0]  SUB_CON0     = 4'h0;
    localparam logic [3:0]  SUB_CON1     = 4'h1;
    localparam logic [3:0]  SUB_CFG      = 4'h6;
    localparam logic [3:0]  SUB_DATA_LO  = 4'h7;
    localparam logic [3:0]  SUB_DATA_HI  = 4'he;
    // ==========================================
    // Field positions
    localparam int          CTL_EIE      = 3;
    localparam int          CTL_SIE      = 2;
    localparam int          CTL_IE       = 1;
    localparam logic [7:0]  CTL_WMASK    = 8'h4f;
    localparam logic [7:0]  CTL_RESET    = 8'h01;
    localparam int          CFG_DIR      = 3;
    localparam logic [7:0]  PEND_STATUS  = 8'h01;
    localparam logic [7:0]  PEND_OBJ15   = 8'h02;
    localparam logic [7:0]  PEND_OBJ1    = 8'h03;

    // Bit-pair write decode: 10 set, 01 clear, else keep
    function automatic logic cosd_pair_upd(logic old, logic [1:0] w);
        logic r;
        r = old;
        if (w == 2'b10) begin
            r = 1'b1;
        end else if (w == 2'b01) begin
            r = 1'b0;
        end
        return r;
    endfunction : cosd_pair_upd
endpackage : cosd_pkg

// ==== rtl/cosd_payload_mem.sv ====
// Purpose: Payload byte store for all message objects
// Assumes: Port B (receive) and port A (software) never hit one byte together
// Notes:   No reset; contents survive reset
`timescale 1ns/10ps
`default_nettype none
module cosd_payload_mem #(
    parameter int AW    = 7,
    parameter int DEPTH = 120
) (
    // Clock
    input  wire logic          clk,
    // Software write port
    input  wire logic          a_we,
    input  wire logic [AW-1:0] a_addr,
    input  wire logic [7:0]    a_data,
    // Receive write port
    input  wire logic          b_we,
    input  wire logic [AW-1:0] b_addr,
    input  wire logic [7:0]    b_data,
    // Registered read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data_q
);
    // ==========================================
    // Storage
    logic [7:0] mem [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("cosd_payload_mem: depth exceeds address range");
    end

    // Writes and registered read, no reset on purpose
    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_data;
        end
        if (b_we) begin
            mem[b_addr] <= b_data;
        end
        if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule : cosd_payload_mem
`default_nettype wire

// ==== rtl/cosd_top.sv ====
// Purpose: Object control pairs, payload registers and interrupt enables over APB
// Assumes: Frame engine events arrive on pclk as one-cycle pulses
// Notes:   One transfer answers on the second access cycle
`timescale 1ns/10ps
`default_nettype none
module cosd_top
    import cosd_pkg::*;
#(
    parameter int NOBJ = 15
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive events from frame engine
    input  wire logic        rx_byte_we,
    input  wire logic [3:0]  rx_byte_obj,
    input  wire logic [2:0]  rx_byte_idx,
    input  wire logic [7:0]  rx_byte_data,
    input  wire logic        rx_done,
    input  wire logic [3:0]  rx_obj,
    input  wire logic        rx_msg_ok,
    // Transmit and remote events
    input  wire logic        tx_done,
    input  wire logic [3:0]  tx_done_obj,
    input  wire logic        remote_req,
    input  wire logic [3:0]  remote_obj,
    // Error events
    input  wire logic        busoff_evt,
    input  wire logic        warn_evt,
    input  wire logic        lec_evt,
    input  wire logic [2:0]  lec_val,
    // Transmit launch and interrupt
    output logic             tx_start,
    output logic      [3:0]  tx_obj,
    output logic             controller_irq_line
);
    if (NOBJ != 15) begin : g_chk
        $error("cosd_top: exactly fifteen objects are supported");
    end

    // ==========================================
    // State
    logic [7:0]      ctl_q, ctl_d;
    logic            rx_success_flag_q, rx_success_flag_d, tx_success_flag_q, tx_success_flag_d, bo_q, bo_d, wn_q, wn_d;
    logic [2:0]      lec_q, lec_d;
    logic            spnd_q, spnd_d, busy_q, busy_d;
    logic [15:1]     object_tx_irq_enable_q, object_tx_irq_enable_d, object_rx_irq_enable_q, object_rx_irq_enable_d, ipnd_q, ipnd_d;
    logic [15:1]     rmt_q, rmt_d, txr_q, txr_d, ovh_q, ovh_d, fresh_q, fresh_d;
    logic [15:1]     ovh_prev_q, txr_prev_q;
    logic [7:0]      cfg_q [15:1];
    logic [7:0]      cfg_d [15:1];
    logic [31:0]     prdata_d;
    logic            pready_d, pslverr_d, tx_start_d, irq_d, rd_pair_q, rd_pair_d;
    logic [3:0]      tx_obj_d;

    // ==========================================
    // Decode
    logic [13:0]     idx;
    logic [3:0]      obj, sub;
    logic            page_hit, obj_hit, data_hit, hit, acc, take, wr;
    logic [6:0]      mem_addr, rx_mem_addr;
    logic [7:0]      mem_rd, pend_val;
    logic [1:0]      wp3, wp2, wp1, wp0;

    always_comb begin
        idx      = paddr[15:2];
        obj      = idx[7:4];
        sub      = idx[3:0];
        page_hit = (idx[13:8] == IDX_PAGE) && (paddr[1:0] == 2'b00);
        obj_hit  = page_hit && (obj != 4'h0);
        data_hit = obj_hit && (sub >= SUB_DATA_LO) && (sub <= SUB_DATA_HI);
        hit      = (paddr[1:0] == 2'b00)
                   && ((idx == IDX_CTL) || (idx == IDX_STAT) || (idx == IDX_PEND)
                       || data_hit
                       || (obj_hit && ((sub == SUB_CON0) || (sub == SUB_CON1)
                                       || (sub == SUB_CFG))));
        acc      = psel && penable;
        take     = acc && pready;
        wr       = take && pwrite;
        // Byte 0 sits at the highest index, byte 7 at the lowest
        mem_addr    = 7'({obj - 4'h1, 3'(SUB_DATA_HI - sub)});
        rx_mem_addr = 7'({rx_byte_obj - 4'h1, rx_byte_idx});
        wp3      = pwdata[7:6];
        wp2      = pwdata[5:4];
        wp1      = pwdata[3:2];
        wp0      = pwdata[1:0];
    end

    // Payload store
    cosd_payload_mem #(.AW(7), .DEPTH(120)) u_mem (
        .clk       (pclk),
        .a_we      (wr && data_hit),
        .a_addr    (mem_addr),
        .a_data    (pwdata[7:0]),
        .b_we      (rx_byte_we && (rx_byte_obj != 4'h0)),
        .b_addr    (rx_mem_addr),
        .b_data    (rx_byte_data),
        .rd_en     (psel && !penable),
        .rd_addr   (mem_addr),
        .rd_data_q (mem_rd)
    );

    // Highest priority pending source: status, object 15, then 1 to 14
    always_comb begin
        pend_val = 8'h00;
        for (int o = 14; o >= 1; o--) begin
            if (ipnd_q[o]) begin
                pend_val = 8'(PEND_OBJ1 + 8'(o - 1));
            end
        end
        if (ipnd_q[15]) begin
            pend_val = PEND_OBJ15;
        end
        if (spnd_q) begin
            pend_val = PEND_STATUS;
        end
    end

    // ==========================================
    // Next state
    always_comb begin
        ctl_d = ctl_q;   rx_success_flag_d = rx_success_flag_q; tx_success_flag_d = tx_success_flag_q; bo_d = bo_q; wn_d = wn_q;
        lec_d = lec_q;   spnd_d = spnd_q; busy_d = busy_q;
        object_tx_irq_enable_d = object_tx_irq_enable_q; object_rx_irq_enable_d = object_rx_irq_enable_q; ipnd_d = ipnd_q; rmt_d = rmt_q;
        txr_d = txr_q;   ovh_d = ovh_q;   fresh_d = fresh_q; cfg_d = cfg_q;
        tx_start_d = 1'b0;
        tx_obj_d   = tx_obj;
        // APB answer: one wait cycle, then pready with registered data
        pready_d  = acc && !pready;
        pslverr_d = 1'b0;
        prdata_d  = prdata;
        rd_pair_d = 1'b0;
        if (acc && !pready) begin
            pslverr_d = !hit;
            rd_pair_d = obj_hit && ((sub == SUB_CON0) || (sub == SUB_CON1));
            prdata_d  = 32'h0000_0000;
            if (idx == IDX_CTL) begin
                prdata_d[7:0] = ctl_q;
            end else if (idx == IDX_STAT) begin
                prdata_d[7:0] = {bo_q, wn_q, 1'b0, rx_success_flag_q, tx_success_flag_q, lec_q};
            end else if (idx == IDX_PEND) begin
                prdata_d[7:0] = pend_val;
            end else if (data_hit) begin
                prdata_d[7:0] = mem_rd;
            end else if (obj_hit && sub == SUB_CON0) begin
                prdata_d[7:0] = {2'b10, object_tx_irq_enable_q[obj], !object_tx_irq_enable_q[obj],
                                 object_rx_irq_enable_q[obj], !object_rx_irq_enable_q[obj], ipnd_q[obj], !ipnd_q[obj]};
            end else if (obj_hit && sub == SUB_CON1) begin
                prdata_d[7:0] = {rmt_q[obj], !rmt_q[obj], txr_q[obj], !txr_q[obj],
                                 ovh_q[obj], !ovh_q[obj], fresh_q[obj], !fresh_q[obj]};
            end else if (obj_hit && sub == SUB_CFG) begin
                prdata_d[7:0] = cfg_q[obj];
            end
        end
        // Software writes first, so hardware sets below win
        if (wr && hit) begin
            if (idx == IDX_CTL) begin
                ctl_d = pwdata[7:0] & CTL_WMASK;
            end else if (idx == IDX_STAT) begin
                bo_d   = bo_q & pwdata[7];
                wn_d   = wn_q & pwdata[6];
                rx_success_flag_d = rx_success_flag_q & pwdata[4];
                tx_success_flag_d = tx_success_flag_q & pwdata[3];
                spnd_d = 1'b0;
            end else if (obj_hit && sub == SUB_CON0) begin
                object_tx_irq_enable_d[obj] = cosd_pair_upd(object_tx_irq_enable_q[obj], wp2);
                object_rx_irq_enable_d[obj] = cosd_pair_upd(object_rx_irq_enable_q[obj], wp1);
                ipnd_d[obj] = cosd_pair_upd(ipnd_q[obj], wp0);
            end else if (obj_hit && sub == SUB_CON1) begin
                rmt_d[obj]   = cosd_pair_upd(rmt_q[obj], wp3);
                txr_d[obj]   = cosd_pair_upd(txr_q[obj], wp2);
                ovh_d[obj]   = cosd_pair_upd(ovh_q[obj], wp1);
                fresh_d[obj] = cosd_pair_upd(fresh_q[obj], wp0);
            end else if (obj_hit && sub == SUB_CFG) begin
                cfg_d[obj] = pwdata[7:0];
            end
        end
        // Receive completion
        if (rx_done && rx_obj != 4'h0) begin
            if (fresh_q[rx_obj]) begin
                ovh_d[rx_obj] = 1'b1;
            end
            fresh_d[rx_obj] = 1'b1;
            if (object_rx_irq_enable_q[rx_obj]) begin
                ipnd_d[rx_obj] = 1'b1;
            end
        end
        if (rx_msg_ok) begin
            rx_success_flag_d = 1'b1;
            if (ctl_q[CTL_SIE]) begin
                spnd_d = 1'b1;
            end
        end
        // Transmit completion
        if (tx_done && tx_done_obj != 4'h0) begin
            txr_d[tx_done_obj] = 1'b0;
            busy_d = 1'b0;
            tx_success_flag_d = 1'b1;
            if (ctl_q[CTL_SIE]) begin
                spnd_d = 1'b1;
            end
            if (object_tx_irq_enable_q[tx_done_obj]) begin
                ipnd_d[tx_done_obj] = 1'b1;
            end
        end
        // Error events and remote requests
        if (busoff_evt || warn_evt) begin
            bo_d = bo_q | busoff_evt;
            wn_d = wn_q | warn_evt;
            if (ctl_q[CTL_EIE]) begin
                spnd_d = 1'b1;
            end
        end
        if (lec_evt) begin
            lec_d = lec_val;
            if (ctl_q[CTL_SIE] && lec_val != lec_q) begin
                spnd_d = 1'b1;
            end
        end
        if (remote_req && remote_obj != 4'h0 && cfg_q[remote_obj][CFG_DIR]) begin
            rmt_d[remote_obj] = 1'b1;
        end
        // Launch: lowest object with a request; editing holds back remote answers
        if (!busy_q) begin
            for (int o = NOBJ; o >= 1; o--) begin
                if ((rmt_q[o] && !ovh_q[o] && cfg_q[o][CFG_DIR]) || txr_q[o]) begin
                    tx_start_d = 1'b1;
                    tx_obj_d   = 4'(o);
                end
            end
            if (tx_start_d) begin
                busy_d           = 1'b1;
                rmt_d[tx_obj_d]  = 1'b0;
                txr_d[tx_obj_d]  = 1'b1;
            end
        end
        // Single shared line, gated by global and source enables
        irq_d = ctl_q[CTL_IE]
                && (spnd_q || (|(ipnd_q & (object_rx_irq_enable_q | object_tx_irq_enable_q))));
    end

    // ==========================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= CTL_RESET; rx_success_flag_q <= 1'b0; tx_success_flag_q <= 1'b0; bo_q <= 1'b0;
            wn_q <= 1'b0; lec_q <= 3'h0; spnd_q <= 1'b0; busy_q <= 1'b0;
            object_tx_irq_enable_q <= '0; object_rx_irq_enable_q <= '0; ipnd_q <= '0; rmt_q <= '0;
            txr_q <= '0; ovh_q <= '0; fresh_q <= '0; ovh_prev_q <= '0; txr_prev_q <= '0;
            for (int o = 1; o <= 15; o++) begin
                cfg_q[o] <= 8'h00;
            end
            prdata <= 32'h0000_0000; pready <= 1'b0; pslverr <= 1'b0;
            rd_pair_q <= 1'b0;
            tx_start <= 1'b0; tx_obj <= 4'h0; controller_irq_line <= 1'b0;
        end else begin
            ctl_q <= ctl_d; rx_success_flag_q <= rx_success_flag_d; tx_success_flag_q <= tx_success_flag_d; bo_q <= bo_d;
            wn_q <= wn_d; lec_q <= lec_d; spnd_q <= spnd_d; busy_q <= busy_d;
            object_tx_irq_enable_q <= object_tx_irq_enable_d; object_rx_irq_enable_q <= object_rx_irq_enable_d; ipnd_q <= ipnd_d; rmt_q <= rmt_d;
            txr_q <= txr_d; ovh_q <= ovh_d; fresh_q <= fresh_d; ovh_prev_q <= ovh_q;
            cfg_q <= cfg_d; txr_prev_q <= txr_q;
            prdata <= prdata_d; pready <= pready_d; pslverr <= pslverr_d;
            rd_pair_q <= rd_pair_d;
            tx_start <= tx_start_d; tx_obj <= tx_obj_d; controller_irq_line <= irq_d;
        end
    end

    // ==========================================
    // Checks
    chk_overwrite_mark: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && rx_obj != 4'h0 && fresh_q[rx_obj] |=> ovh_q[$past(rx_obj)])
        else $error("overwrite flag not set on second store");
    chk_fresh_set: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && rx_obj != 4'h0 |=> fresh_q[$past(rx_obj)])
        else $error("fresh flag not set after store");
    chk_edit_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        tx_start && !txr_prev_q[tx_obj] |-> !ovh_prev_q[tx_obj])
        else $error("remote answer sent while host editing");
    chk_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
        controller_irq_line |-> $past(ctl_q[CTL_IE])
                                && ($past(spnd_q) || $past(|ipnd_q)))
        else $error("interrupt without enable and source");
    chk_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_q[CTL_IE] && rx_msg_ok && ctl_q[CTL_SIE]
        |=> spnd_q && pend_val == PEND_STATUS && !controller_irq_line)
        else $error("pending not updated or interrupt raised while disabled");
    chk_rx_success_flag_req: assert property (@(posedge pclk) disable iff (!presetn)
        rx_msg_ok && ctl_q[CTL_SIE] |=> spnd_q && rx_success_flag_q)
        else $error("valid message gave no receive-ok request");
    chk_two_req: assert property (@(posedge pclk) disable iff (!presetn)
        rx_msg_ok && rx_done && rx_obj != 4'h0 && ctl_q[CTL_SIE] && object_rx_irq_enable_q[rx_obj]
        |=> spnd_q && ipnd_q[$past(rx_obj)])
        else $error("two requests expected for one message");
    chk_err_req: assert property (@(posedge pclk) disable iff (!presetn)
        busoff_evt && ctl_q[CTL_EIE] ##1 ctl_q[CTL_IE] |=> controller_irq_line)
        else $error("bus-off with enables gave no interrupt");
    chk_pair_read: assert property (@(posedge pclk) disable iff (!presetn)
        pready && rd_pair_q |-> prdata[7] != prdata[6] && prdata[5] != prdata[4]
                                && prdata[3] != prdata[2] && prdata[1] != prdata[0])
        else $error("bit pair read not complementary");
endmodule : cosd_top
`default_nettype wire

// ==== test/cosd_bus_model.sv ====
// Purpose: Stand-in for the frame engine on the CAN side
// Assumes: The bench calls one task at a time
// Notes:   Idle byte data toggles so that a stale byte never looks valid
`timescale 1ns/10ps
`default_nettype none
module cosd_bus_model (
    // Clock
    input  wire logic       pclk,
    // Launch from the block
    input  wire logic       tx_start,
    input  wire logic [3:0] tx_obj,
    // Events into the block
    output logic            tx_done,
    output logic      [3:0] tx_done_obj,
    output logic            rx_byte_we,
    output logic      [3:0] rx_byte_obj,
    output logic      [2:0] rx_byte_idx,
    output logic      [7:0] rx_byte_data,
    output logic            rx_done,
    output logic      [3:0] rx_obj,
    output logic            rx_msg_ok,
    output logic            remote_req,
    output logic      [3:0] remote_obj
);
    // ==========================================
    // Frame engine behaviour
    logic [3:0] cur;
    // Quiet lines at time zero
    initial begin
        {tx_done, rx_byte_we, rx_done, rx_msg_ok, remote_req} = '0;
        {tx_done_obj, rx_byte_obj, rx_obj, remote_obj, cur} = '0;
        rx_byte_idx = '0;
        rx_byte_data = 8'h00;
    end
    // Finish each launched frame a few cycles later
    always begin
        @(posedge pclk);
        if (tx_start === 1'b1) begin
            cur = tx_obj;
            repeat (4) @(posedge pclk);
            tx_done_obj <= cur;
            tx_done     <= 1'b1;
            @(posedge pclk);
            tx_done     <= 1'b0;
        end
    end
    // Store n bytes base+k into obj, then report a valid frame
    task automatic rx_frame(input logic [3:0] obj, input logic [7:0] base, input int n);
        for (int k = 0; k < n; k++) begin
            rx_byte_we   <= 1'b1;
            rx_byte_obj  <= obj;
            rx_byte_idx  <= 3'(k);
            rx_byte_data <= base + 8'(k);
            @(posedge pclk);
        end
        rx_byte_we   <= 1'b0;
        rx_byte_data <= ~rx_byte_data;
        rx_done      <= (obj != 4'h0);
        rx_obj       <= obj;
        rx_msg_ok    <= 1'b1;
        @(posedge pclk);
        rx_done      <= 1'b0;
        rx_msg_ok    <= 1'b0;
        @(posedge pclk);
    endtask : rx_frame
    // Remote frame asking for obj
    task automatic remote(input logic [3:0] obj);
        remote_req <= 1'b1;
        remote_obj <= obj;
        @(posedge pclk);
        remote_req <= 1'b0;
        @(posedge pclk);
    endtask : remote
endmodule : cosd_bus_model
`default_nettype wire

// ==== test/can_object_status_data_irq_enable_test.sv ====
// Purpose: Self-checking bench for object status, payload and irq enables
// Assumes: APB byte address is index * 4; one register per word
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module can_object_status_data_irq_enable_test;
    import cosd_pkg::*;
    // ==========================================
    // Signals and instances
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  tx_obj, rx_byte_obj, rx_obj, tx_done_obj, remote_obj, last_obj;
    logic [2:0]  rx_byte_idx, lec_val;
    logic [7:0]  rx_byte_data, rd_v;
    logic        rx_byte_we, rx_done, rx_msg_ok, tx_done, remote_req, tx_start;
    logic        busoff_evt, warn_evt, lec_evt, err_v, controller_irq_line;
    int          bad_count, n_compared, n_start = 0;
    localparam logic [15:0] A_CTL  = {IDX_CTL, 2'b00};
    localparam logic [15:0] A_STAT = {IDX_STAT, 2'b00};
    localparam logic [15:0] A_PEND = {IDX_PEND, 2'b00};
    cosd_top #(.NOBJ(15)) cosd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_byte_we(rx_byte_we),
        .rx_byte_obj(rx_byte_obj), .rx_byte_idx(rx_byte_idx), .rx_byte_data(rx_byte_data),
        .rx_done(rx_done), .rx_obj(rx_obj), .rx_msg_ok(rx_msg_ok), .tx_done(tx_done),
        .tx_done_obj(tx_done_obj), .remote_req(remote_req), .remote_obj(remote_obj),
        .busoff_evt(busoff_evt), .warn_evt(warn_evt), .lec_evt(lec_evt), .lec_val(lec_val),
        .tx_start(tx_start), .tx_obj(tx_obj), .controller_irq_line(controller_irq_line));
    cosd_bus_model cosd_bus_model_i (.pclk(pclk), .tx_start(tx_start), .tx_obj(tx_obj),
        .tx_done(tx_done), .tx_done_obj(tx_done_obj), .rx_byte_we(rx_byte_we),
        .rx_byte_obj(rx_byte_obj), .rx_byte_idx(rx_byte_idx), .rx_byte_data(rx_byte_data),
        .rx_done(rx_done), .rx_obj(rx_obj), .rx_msg_ok(rx_msg_ok),
        .remote_req(remote_req), .remote_obj(remote_obj));
    // Clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Count launches and remember the object
    always @(posedge pclk) begin
        if (tx_start === 1'b1) begin
            n_start  <= n_start + 1;
            last_obj <= tx_obj;
        end
    end
    // ==========================================
    // Bus helpers
    function automatic logic [15:0] oa(input logic [3:0] x, input logic [3:0] s);
        return {IDX_PAGE, x, s, 2'b00};
    endfunction : oa
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v    = prdata[7:0];
        err_v   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
        apb(1'b0, a, 8'h00);
        `CHK(nm, e, rd_v)
    endtask : rd
    // ==========================================
    // Scenarios
    task automatic t_reset_vals();
        rd(A_CTL, CTL_RESET, "ctl reset");
        rd(oa(4'h2, SUB_CON1), 8'h55, "con1 reset");
        wr(oa(4'hf, SUB_CON1), 8'hfd);
        wr(A_CTL, 8'h4f);
        rd(A_CTL, CTL_WMASK, "ctl reserved");
        wr(A_CTL, 8'h01);
        apb(1'b0, 16'h0004, 8'h00);
        `CHK("unmapped err", 1'b1, err_v)
        `CHK("irq idle", 1'b0, controller_irq_line)
    endtask : t_reset_vals
    task automatic t_pairs();
        logic [7:0] wv [4] = '{8'h02, 8'hf9, 8'hff, 8'hf7};
        logic [7:0] ev [4] = '{8'h56, 8'h59, 8'h59, 8'h55};
        for (int i = 0; i < 4; i++) begin
            wr(oa(4'h2, SUB_CON1), wv[i]);
            rd(oa(4'h2, SUB_CON1), ev[i], "con1 pair");
        end
    endtask : t_pairs
    task automatic t_rx_store();
        cosd_bus_model_i.rx_frame(4'h3, 8'h30, 8);
        rd(oa(4'h3, SUB_CON1), 8'h56, "con1 first rx");
        for (int k = 0; k < 8; k++) begin
            rd(oa(4'h3, SUB_DATA_HI - 4'(k)), 8'h30 + 8'(k), "payload");
        end
        cosd_bus_model_i.rx_frame(4'h3, 8'h40, 2);
        rd(oa(4'h3, SUB_CON1), 8'h5a, "con1 overwrite");
        rd(oa(4'h3, SUB_DATA_HI - 4'h1), 8'h41, "payload again");
    endtask : t_rx_store
    task automatic t_irq();
        logic [7:0] cv [3] = '{8'h0a, 8'h08, 8'h02};
        logic       iv [3] = '{1'b1, 1'b0, 1'b0};
        wr(oa(4'h3, SUB_CON0), 8'hfb);
        wr(A_CTL, 8'h06);
        cosd_bus_model_i.rx_frame(4'h3, 8'h50, 1);
        repeat (3) @(posedge pclk);
        `CHK("irq rx", 1'b1, controller_irq_line)
        rd(A_PEND, PEND_STATUS, "pend status");
        wr(A_STAT, 8'h00);
        rd(A_PEND, PEND_OBJ1 + 8'h02, "pend obj");
        wr(oa(4'h3, SUB_CON0), 8'hfd);
        rd(A_PEND, 8'h00, "pend none");
        `CHK("irq cleared", 1'b0, controller_irq_line)
        wr(A_CTL, 8'h04);
        cosd_bus_model_i.rx_frame(4'h0, 8'h00, 0);
        repeat (3) @(posedge pclk);
        `CHK("irq global off", 1'b0, controller_irq_line)
        rd(A_PEND, PEND_STATUS, "pend global off");
        wr(A_STAT, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(A_CTL, cv[i]);
            {busoff_evt, warn_evt} <= (i == 1) ? 2'b01 : 2'b10;
            @(posedge pclk);
            {busoff_evt, warn_evt} <= 2'b00;
            repeat (3) @(posedge pclk);
            `CHK("irq error", iv[i], controller_irq_line)
            wr(A_STAT, 8'h00);
        end
        wr(A_CTL, 8'h06);
        lec_evt <= 1'b1;
        lec_val <= 3'h2;
        @(posedge pclk);
        lec_evt <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("irq lec", 1'b1, controller_irq_line)
        rd(A_STAT, 8'h02, "lec kind");
        wr(A_STAT, 8'h00);
        wr(A_CTL, 8'h00);
    endtask : t_irq
    task automatic t_remote();
        wr(oa(4'h4, SUB_CFG), 8'h08);
        wr(oa(4'h4, SUB_CON1), 8'hfb);
        cosd_bus_model_i.remote(4'h4);
        repeat (8) @(posedge pclk);
        `CHK("no launch", 0, n_start)
        wr(oa(4'h4, SUB_CON1), 8'hfe);
        wr(oa(4'h4, SUB_CON1), 8'hf7);
        repeat (4) @(posedge pclk);
        `CHK("launch count", 1, n_start)
        `CHK("launch obj", 4'h4, last_obj)
        repeat (4) @(posedge pclk);
        rd(A_STAT, 8'h0a, "tx ok");
        rd(oa(4'h4, SUB_CON1), 8'h56, "con1 after tx");
    endtask : t_remote
    task automatic t_keep_payload();
        wr(oa(4'h5, SUB_DATA_LO), 8'ha5);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(oa(4'h5, SUB_DATA_LO), 8'ha5, "payload kept");
        rd(A_CTL, CTL_RESET, "ctl again");
    endtask : t_keep_payload
    // ==========================================
    // Verdict, watchdog and main sequence
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        {busoff_evt, warn_evt, lec_evt} = '0;
        lec_val = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_vals();
        t_pairs();
        t_rx_store();
        t_irq();
        t_remote();
        t_keep_payload();
        end_of_test();
    end
endmodule : can_object_status_data_irq_enable_test
`default_nettype wire
